// File: dps_pkg.sv
// Shared constants, field layouts and types of the program sequencer
package dps_pkg;

  localparam int CLK_PERIOD_NS = 8;
  localparam int ICYC_REAL_NS = 160;
  localparam int ICYC_WIDE_NS = 320;
  localparam int ICYC_REAL_CYC = ICYC_REAL_NS / CLK_PERIOD_NS;
  localparam int ICYC_WIDE_CYC = ICYC_WIDE_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] ICYC_REAL_LAST = CNT_W'(ICYC_REAL_CYC - 1);
  localparam logic [CNT_W-1:0] ICYC_WIDE_LAST = CNT_W'(ICYC_WIDE_CYC - 1);
  localparam logic [CNT_W-1:0] ICYC_REAL_HALF = CNT_W'(ICYC_REAL_CYC / 2);
  localparam logic [CNT_W-1:0] ICYC_WIDE_HALF = CNT_W'(ICYC_WIDE_CYC / 2);
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

  localparam int ROM_WORDS = 1280;
  localparam int ROM_AW = 11;
  localparam logic [ROM_AW-1:0] ROM_ADDR_ONE = 11'h001;
  localparam logic [15:0] ROM_LIMIT = 16'h0500;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] REPEAT_ONE = 8'h01;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] REG_INSTR = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PROG_CNT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_RET_ADDR = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_LOOP = 8'h10;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h14;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] REG_COEF = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_ROM_ADDR = 8'h20;
  localparam logic [ADDR_W-1:0] REG_ROM_DATA = 8'h24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [3:0] COND_EDGE_FIRST = 4'h3;
  localparam logic [3:0] COND_LOOP = 4'h7;

  typedef enum logic [1:0] {
    MODE_REAL = 2'h0,
    MODE_COMPLEX = 2'h1,
    MODE_DOUBLE = 2'h2,
    MODE_RSVD = 2'h3
  } dps_mode_t;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_JUMP = 4'h1,
    OP_CALL = 4'h2,
    OP_RETURN = 4'h3,
    OP_BRANCH = 4'h4,
    OP_LOOP = 4'h5
  } dps_op_t;

  typedef struct packed {
    logic [3:0] op;
    logic [3:0] cond_sel;
    logic cond_pol;
    logic [6:0] spare;
    logic [15:0] imm;
  } dps_instr_t;

  typedef struct packed {
    logic [2:0] loop_start_delay;
    logic [7:0] loop_repeat_count;
    logic [3:0] loop_body_length;
  } dps_loop_word_t;

  typedef struct packed {
    logic [7:0] soft_flags;
    logic ack_value;
    logic avail_value;
    logic ack_drive;
    logic avail_drive;
    logic ext_fetch;
    logic [2:0] level_pol;
  } dps_ctrl_t;

  typedef struct packed {
    logic coef_oe;
    logic [8:0] coef_addr;
  } dps_coef_t;

  typedef struct packed {
    logic [15:0] fetch_addr;
    logic [5:0] spare;
    dps_coef_t coef;
  } dps_ins_bus_t;

  localparam dps_ctrl_t CTRL_RESET = 16'h0007;
  localparam dps_coef_t COEF_RESET = 10'h000;
  localparam dps_loop_word_t LOOP_RESET = 15'h0000;

endpackage : dps_pkg

// File: dps_sequencer.sv
// Program flow controller with AXI4-Lite register access
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
module dps_sequencer (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [dps_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [dps_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [2:0] branch_level_inputs_in,
  input wire logic [1:0] branch_edge_inputs_in,
  input wire logic bus_avail_pin_in,
  output logic bus_avail_pin_out,
  output logic bus_avail_pin_oe_out,
  input wire logic transfer_ack_pin_in,
  output logic transfer_ack_pin_out,
  output logic transfer_ack_pin_oe_out,
  input wire logic halt_in,
  output logic instruction_cycle_clock_out,
  input wire logic [31:0] ins_bus_in,
  output logic [31:0] ins_bus_out,
  output logic ins_bus_oe_out
);
  import dps_pkg::*;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction : wmerge

  dps_mode_t mode_q;
  dps_ctrl_t ctrl_q;
  dps_coef_t coef_q;
  dps_loop_word_t loop_counter_q, loop_counter_d;
  dps_instr_t instruction_register_q, instr;
  logic [15:0] program_counter_q, program_counter_d;
  logic [15:0] return_address_register_q, return_address_register_d;
  logic [15:0] loop_start_q, loop_start_d, loop_end_q, loop_end_d;
  logic loop_act_q, loop_act_d;
  logic [31:0] rom_q [0:ROM_WORDS-1];
  logic [ROM_AW-1:0] rom_addr_q;
  logic [31:0] rom_word;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, rd_val;
  logic wr_go, wr_hit, rd_hit;

  assign wr_go = !awready_q && !wready_q && !bvalid_q;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      awready_q <= 1'b1;
      awaddr_q <= '0;
    end else if (s_axi_awvalid_in && awready_q) begin
      awready_q <= 1'b0;
      awaddr_q <= s_axi_awaddr_in;
    end else if (bvalid_q && s_axi_bready_in) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wready_q <= 1'b1;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid_in && wready_q) begin
      wready_q <= 1'b0;
      wdata_q <= s_axi_wdata_in;
      wstrb_q <= s_axi_wstrb_in;
    end else if (bvalid_q && s_axi_bready_in) begin
      wready_q <= 1'b1;
    end
  end

  always_comb begin
    case (awaddr_q)
      REG_MODE, REG_PROG_CNT, REG_RET_ADDR, REG_LOOP, REG_CTRL, REG_COEF,
      REG_ROM_ADDR, REG_ROM_DATA: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      bvalid_q <= 1'b0;
    end
  end

  // Software writes only; the sequencer owns the remaining state
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_q <= MODE_REAL;
      ctrl_q <= CTRL_RESET;
      coef_q <= COEF_RESET;
      rom_addr_q <= '0;
    end else if (wr_go) begin
      case (awaddr_q)
        REG_MODE: begin
          // Reserved encoding is dropped so the cycle length stays defined
          if (wstrb_q[0] && dps_mode_t'(wdata_q[1:0]) != MODE_RSVD) begin
            mode_q <= dps_mode_t'(wdata_q[1:0]);
          end
        end
        REG_CTRL: ctrl_q <= dps_ctrl_t'(16'(wmerge({16'h0000, ctrl_q}, wdata_q, wstrb_q)));
        REG_COEF: coef_q <= dps_coef_t'(10'(wmerge({22'h000000, coef_q}, wdata_q, wstrb_q)));
        REG_ROM_ADDR: begin
          rom_addr_q <= ROM_AW'(wmerge({21'h000000, rom_addr_q}, wdata_q, wstrb_q));
        end
        REG_ROM_DATA: rom_addr_q <= rom_addr_q + ROM_ADDR_ONE;
        default: ;
      endcase
    end
  end

  // Store is loaded by software only; program side never writes it
  always_ff @(posedge core_clk_in) begin
    if (wr_go && awaddr_q == REG_ROM_DATA && 16'(rom_addr_q) < ROM_LIMIT) begin
      rom_q[rom_addr_q] <= wdata_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge latches
  logic [7:0] pin_raw, pin_s1, pin_s2;
  logic [3:0] edge_s3, edge_fall, edge_clr, edge_lat_q, edge_mask;
  logic [31:0] ins_s1, ins_s2;
  logic halt_s;
  logic [2:0] lvl_s;

  assign pin_raw = {halt_in, branch_level_inputs_in, transfer_ack_pin_in, bus_avail_pin_in,
                    branch_edge_inputs_in};
  assign halt_s = pin_s2[7];
  assign lvl_s = pin_s2[6:4];
  assign edge_mask = {ctrl_q.ack_drive, ctrl_q.avail_drive, 2'b00};
  assign edge_fall = edge_s3 & ~pin_s2[3:0] & ~edge_mask;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      edge_s3 <= '0;
      ins_s1 <= '0;
      ins_s2 <= '0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      edge_s3 <= pin_s2[3:0];
      ins_s1 <= ins_bus_in;
      ins_s2 <= ins_s1;
    end
  end

  // Shared pins: driving a pin hides its edge input from the sequencer
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bus_avail_pin_out <= 1'b0;
      bus_avail_pin_oe_out <= 1'b0;
      transfer_ack_pin_out <= 1'b0;
      transfer_ack_pin_oe_out <= 1'b0;
    end else begin
      bus_avail_pin_out <= ctrl_q.avail_value;
      bus_avail_pin_oe_out <= ctrl_q.avail_drive;
      transfer_ack_pin_out <= ctrl_q.ack_value;
      transfer_ack_pin_oe_out <= ctrl_q.ack_drive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction cycle timing
  logic [CNT_W-1:0] cyc_cnt_q, cyc_cnt_d, cyc_last, cyc_half;
  logic tick, exec;

  assign cyc_last = (mode_q == MODE_REAL) ? ICYC_REAL_LAST : ICYC_WIDE_LAST;
  assign cyc_half = (mode_q == MODE_REAL) ? ICYC_REAL_HALF : ICYC_WIDE_HALF;
  assign tick = cyc_cnt_q >= cyc_last;
  assign cyc_cnt_d = tick ? '0 : cyc_cnt_q + CNT_ONE;
  assign exec = tick && !halt_s;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cyc_cnt_q <= '0;
      instruction_cycle_clock_out <= 1'b0;
    end else begin
      cyc_cnt_q <= cyc_cnt_d;
      instruction_cycle_clock_out <= cyc_cnt_d < cyc_half;
    end
  end

  // Address half drives, data half listens; data is sampled at the tick
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ins_bus_out <= '0;
      ins_bus_oe_out <= 1'b0;
    end else begin
      ins_bus_out <= {program_counter_q, 6'h00, coef_q};
      ins_bus_oe_out <= ctrl_q.ext_fetch && cyc_cnt_d < cyc_half;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  logic [15:0] cond_vec;
  logic taken, wr_prog, wr_ret, wr_loop;

  assign rom_word = (program_counter_q < ROM_LIMIT) ?
                    rom_q[program_counter_q[ROM_AW-1:0]] : '0;
  assign instr = ctrl_q.ext_fetch ? dps_instr_t'(ins_s2) : dps_instr_t'(rom_word);
  assign cond_vec = {ctrl_q.soft_flags, loop_act_q, edge_lat_q,
                     ~(lvl_s ^ ctrl_q.level_pol)};
  assign taken = cond_vec[instr.cond_sel] == instr.cond_pol;
  assign wr_prog = wr_go && awaddr_q == REG_PROG_CNT;
  assign wr_ret = wr_go && awaddr_q == REG_RET_ADDR;
  assign wr_loop = wr_go && awaddr_q == REG_LOOP;

  generate
    for (genvar i = 0; i < 4; i++) begin : g_edge
      assign edge_clr[i] = exec && instr.op == OP_BRANCH &&
                           instr.cond_sel == COND_EDGE_FIRST + 4'(i);
      // A new edge in the testing cycle stays latched
      always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          edge_lat_q[i] <= 1'b0;
        end else begin
          edge_lat_q[i] <= edge_fall[i] || (edge_lat_q[i] && !edge_clr[i]);
        end
      end
    end
  endgenerate

  always_comb begin
    program_counter_d = program_counter_q + PC_STEP;
    return_address_register_d = return_address_register_q;
    loop_counter_d = loop_counter_q;
    loop_start_d = loop_start_q;
    loop_end_d = loop_end_q;
    loop_act_d = loop_act_q;
    if (loop_act_q && program_counter_q == loop_end_q) begin
      if (loop_counter_q.loop_repeat_count > REPEAT_ONE) begin
        program_counter_d = loop_start_q;
        loop_counter_d.loop_repeat_count = loop_counter_q.loop_repeat_count - REPEAT_ONE;
      end else begin
        loop_act_d = 1'b0;
      end
    end
    case (dps_op_t'(instr.op))
      OP_JUMP: program_counter_d = instr.imm;
      OP_CALL: begin
        return_address_register_d = program_counter_q + PC_STEP;
        program_counter_d = instr.imm;
      end
      OP_RETURN: program_counter_d = return_address_register_q;
      OP_BRANCH: begin
        if (taken) begin
          program_counter_d = instr.imm;
        end
      end
      OP_LOOP: begin
        loop_counter_d = dps_loop_word_t'(instr.imm[14:0]);
        loop_start_d = program_counter_q + PC_STEP +
                       16'(loop_counter_d.loop_start_delay);
        loop_end_d = loop_start_d + 16'(loop_counter_d.loop_body_length) - PC_STEP;
        loop_act_d = loop_counter_d.loop_body_length != '0 &&
                     loop_counter_d.loop_repeat_count != '0;
      end
      default: ;
    endcase
  end

  // Halt simply withholds exec, so release resumes at the frozen address
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      program_counter_q <= PC_RESET;
      return_address_register_q <= PC_RESET;
      instruction_register_q <= '0;
      loop_counter_q <= LOOP_RESET;
      loop_start_q <= PC_RESET;
      loop_end_q <= PC_RESET;
      loop_act_q <= 1'b0;
    end else begin
      if (wr_prog) begin
        program_counter_q <= 16'(wmerge({16'h0000, program_counter_q}, wdata_q, wstrb_q));
      end else if (exec) begin
        program_counter_q <= program_counter_d;
      end
      if (wr_ret) begin
        return_address_register_q <= 16'(wmerge({16'h0000, return_address_register_q},
                                                wdata_q, wstrb_q));
      end else if (exec) begin
        return_address_register_q <= return_address_register_d;
      end
      if (wr_loop) begin
        loop_counter_q <= dps_loop_word_t'(15'(wmerge({17'h00000, loop_counter_q},
                                                      wdata_q, wstrb_q)));
      end else if (exec) begin
        loop_counter_q <= loop_counter_d;
      end
      if (exec) begin
        instruction_register_q <= instr;
        loop_start_q <= loop_start_d;
        loop_end_q <= loop_end_d;
        loop_act_q <= loop_act_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read path
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr_in)
      REG_MODE: rd_val = {30'h00000000, mode_q};
      REG_INSTR: rd_val = instruction_register_q;
      REG_PROG_CNT: rd_val = {16'h0000, program_counter_q};
      REG_RET_ADDR: rd_val = {16'h0000, return_address_register_q};
      REG_LOOP: rd_val = {17'h00000, loop_counter_q};
      REG_CTRL: rd_val = {16'h0000, ctrl_q};
      REG_STATUS: rd_val = {23'h000000, loop_act_q, halt_s, lvl_s, edge_lat_q};
      REG_COEF: rd_val = {22'h000000, coef_q};
      REG_ROM_ADDR: rd_val = {21'h000000, rom_addr_q};
      default: begin
        rd_val = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid_in && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready_in) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out = wready_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = arready_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  logic [CNT_W-1:0] gap_q;
  logic mode_chg_q;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gap_q <= '0;
      mode_chg_q <= 1'b1;
    end else begin
      gap_q <= tick ? '0 : gap_q + CNT_ONE;
      mode_chg_q <= (wr_go && awaddr_q == REG_MODE) || (mode_chg_q && !tick);
    end
  end

  a_halt_freeze_pc: assert property (halt_s && !wr_prog |=>
    program_counter_q == $past(program_counter_q)) else $error("counter moved in halt");
  a_halt_freeze_loop: assert property (halt_s && !wr_loop |=>
    loop_counter_q == $past(loop_counter_q)) else $error("loop moved in halt");
  a_icyc_real_period: assert property (tick && !mode_chg_q && mode_q == MODE_REAL |->
    gap_q == ICYC_REAL_LAST) else $error("real cycle not 20 clocks");
  a_icyc_wide_period: assert property (tick && !mode_chg_q && mode_q != MODE_REAL |->
    gap_q == ICYC_WIDE_LAST) else $error("wide cycle not 40 clocks");
  a_edge_latch_set: assert property (edge_fall[0] |=> edge_lat_q[0])
    else $error("edge not latched");
  a_edge_test_clear: assert property (edge_clr[0] && !edge_fall[0] |=> !edge_lat_q[0])
    else $error("edge latch not cleared");
  a_call_saves_ret: assert property (exec && instr.op == OP_CALL && !wr_ret |=>
    return_address_register_q == $past(program_counter_q) + PC_STEP) else $error("bad return");
  a_ir_loads: assert property (exec |=> instruction_register_q == $past(instr))
    else $error("instruction not loaded");
  a_branch_target: assert property (exec && instr.op == OP_BRANCH && taken && !wr_prog |=>
    program_counter_q == $past(instr.imm)) else $error("branch missed");
  a_coef_on_bus: assert property (ins_bus_oe_out |-> ##0
    ins_bus_out[9:0] == $past(coef_q)) else $error("coefficient address wrong");

  c_halt_release: cover property (halt_s ##1 !halt_s [*3] ##0 exec);
  c_loop_wrap: cover property (exec && loop_act_q && program_counter_q == loop_end_q &&
    loop_counter_q.loop_repeat_count > REPEAT_ONE);
  c_edge_branch: cover property (edge_clr[0] && taken);

endmodule : dps_sequencer

// File: dps_ext_rom.sv
// External program memory model on the two-way instruction bus
module dps_ext_rom (
  input wire logic core_clk_in,
  input wire logic [31:0] bus_out_in,
  input wire logic bus_oe_in,
  output logic [31:0] bus_in_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:15];
  logic [15:0] addr_q;

  // Every word jumps to 7, so a run from this memory ends parked at 7
  initial begin
    foreach (mem[i]) mem[i] = 32'h1000_0007;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address is latched while the device drives the bus
  always_ff @(posedge core_clk_in) begin
    if (bus_oe_in) addr_q <= bus_out_in[31:16];
  end

  // Wire level: device value while it drives, else the addressed word
  assign bus_in_out = bus_oe_in ? bus_out_in : mem[addr_q[3:0]];
endmodule : dps_ext_rom

// File: dps_sequencer_tb.sv
// Self-checking testbench of the program sequencer
module dps_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dps_pkg::*;
  `define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin errors++; \
    $display("mismatch %s exp %h got %h", n, e, a); end end

  logic clk = 0, nrst = 0, halt = 1;
  logic [7:0] awa = 0, ara = 0;
  logic awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0;
  logic [31:0] wd = 0, v, rdat, ibo, ibi;
  logic [1:0] rsp, br, rr, edg = 2'h3;
  logic [2:0] lvl = 0, pol;
  logic [14:0] lw;
  logic [9:0] cf;
  logic ba_d = 1, ak_d = 1;
  logic awr, wr_r, bv, arr, rv, ba_o, ba_oe, ak_o, ak_oe, icc, ioe;
  int errors = 0, checks = 0, n;
  logic [31:0] prog [6] = '{32'h2000_0003, 32'h4380_0005, 32'h1000_0002,
    32'h3000_0000, 32'h0, 32'h1000_0005};
  // Loop at 8: one delay slot, body 10..11, three passes, then a level branch
  logic [31:0] prog2 [7] = '{32'h5000_1032, 32'h0, 32'h0, 32'h0, 32'h4080_000e,
    32'h1000_000d, 32'h1000_000e};

  always #4 clk = ~clk;

  dps_sequencer dut_u (.core_clk_in(clk), .nrst_in(nrst), .s_axi_awaddr_in(awa),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_r),
    .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(brd),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rrd), .branch_level_inputs_in(lvl), .branch_edge_inputs_in(edg),
    .bus_avail_pin_in(ba_oe ? ba_o : ba_d), .bus_avail_pin_out(ba_o),
    .bus_avail_pin_oe_out(ba_oe), .transfer_ack_pin_in(ak_oe ? ak_o : ak_d),
    .transfer_ack_pin_out(ak_o), .transfer_ack_pin_oe_out(ak_oe), .halt_in(halt),
    .instruction_cycle_clock_out(icc), .ins_bus_in(ibi), .ins_bus_out(ibo),
    .ins_bus_oe_out(ioe));

  dps_ext_rom ext_u (.core_clk_in(clk), .bus_out_in(ibo), .bus_oe_in(ioe),
    .bus_in_out(ibi));

  ////////////////////////////////////////////////////////////////////////////
  // Leading edge wait keeps back-to-back calls from double driving
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    brd <= 1;
    forever begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wr_r) wv <= 0;
      if (bv) break;
    end
    brd <= 0;
    rsp = br;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rrd <= 1;
    forever begin
      @(posedge clk);
      if (arr) arv <= 0;
      if (rv) break;
    end
    rrd <= 0;
    v = rdat;
    rsp = rr;
  endtask : rd

  task automatic cr(input string s, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(s, e, v)
  endtask : cr

  task automatic per(output int c);
    realtime t;
    @(posedge icc);
    t = $realtime;
    @(posedge icc);
    c = int'(($realtime - t) / 8.0);
  endtask : per

  // Level branch lands on 14 when pin matches polarity, else parks at 13
  function automatic logic [31:0] lvl_pc(input logic l, input logic p);
    return (l == p) ? 32'he : 32'hd;
  endfunction : lvl_pc

  task automatic complete_run;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h3dd91a8f));
    repeat (2) @(posedge clk);
    nrst <= 1;
    cr("mode", REG_MODE, 32'h0);
    cr("pc", REG_PROG_CNT, 32'h0);
    cr("ctrl", REG_CTRL, 32'h7);
    cr("unmapped", 8'h28, 32'h0);
    `CHK("rresp", RESP_SLVERR, rsp)
    wr(REG_INSTR, 32'h5);
    `CHK("bresp", RESP_SLVERR, rsp)
    edg <= 2'h0;
    ba_d <= 0;
    ak_d <= 0;
    lvl <= 3'($urandom);
    repeat (6) @(posedge clk);
    rd(REG_STATUS);
    `CHK("status", {2'b01, lvl, 4'hf}, v[8:0])
    wr(REG_ROM_ADDR, 32'h0);
    foreach (prog[i]) wr(REG_ROM_DATA, prog[i]);
    repeat (100) @(posedge clk);
    cr("pc", REG_PROG_CNT, 32'h0);
    halt <= 0;
    repeat (400) @(posedge clk);
    halt <= 1;
    repeat (10) @(posedge clk);
    cr("pc", REG_PROG_CNT, 32'h5);
    cr("rar", REG_RET_ADDR, 32'h1);
    cr("instr", REG_INSTR, 32'h1000_0005);
    rd(REG_STATUS);
    `CHK("latch", 4'he, v[3:0])
    lw = 15'($urandom);
    wr(REG_LOOP, {17'h0, lw});
    cr("loop", REG_LOOP, {17'h0, lw});
    wr(REG_LOOP, 32'h0);
    for (int m = 0; m < 3; m++) begin
      wr(REG_MODE, 32'(m));
      cr("mode", REG_MODE, 32'(m));
      per(n);
      per(n);
      `CHK("period", (m == 0) ? ICYC_REAL_CYC : ICYC_WIDE_CYC, n)
    end
    wr(REG_MODE, 32'h3);
    cr("mode", REG_MODE, 32'h2);
    wr(REG_MODE, 32'h0);
    cf = 10'($urandom);
    wr(REG_COEF, {22'h0, cf});
    wr(REG_CTRL, 32'hf);
    halt <= 0;
    repeat (400) @(posedge clk);
    @(posedge clk iff ioe);
    `CHK("coef", cf, ibo[9:0])
    `CHK("fetch", 16'h7, ibo[31:16])
    halt <= 1;
    repeat (10) @(posedge clk);
    cr("pc", REG_PROG_CNT, 32'h7);
    wr(REG_CTRL, 32'h57);
    repeat (2) @(posedge clk);
    `CHK("ba_oe", 1'b1, ba_oe)
    `CHK("ba", 1'b1, ba_o)
    `CHK("ak_oe", 1'b0, ak_oe)
    pol = 3'($urandom);
    wr(REG_CTRL, {29'h0, pol});
    wr(REG_ROM_ADDR, 32'h8);
    foreach (prog2[i]) wr(REG_ROM_DATA, prog2[i]);
    wr(REG_PROG_CNT, 32'h8);
    halt <= 0;
    repeat (400) @(posedge clk);
    halt <= 1;
    repeat (10) @(posedge clk);
    `CHK("ba_off", 1'b0, ba_oe)
    cr("lvl_pc", REG_PROG_CNT, lvl_pc(lvl[0], pol[0]));
    cr("loop_end", REG_LOOP, 32'h1012);
    rd(REG_STATUS);
    `CHK("loop_act", 1'b0, v[8])
    complete_run();
  end

  // Whole run is under 3000 cycles; ten times that means a hang
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    complete_run();
  end
endmodule : dps_sequencer_tb
